// ==== verilog/sgsc_pkg.sv ====
// shared types and constants for the servo gain switch control block
package sgsc_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned TICK_NS = 166000;
    // one tick is 166 us; 25 MHz gives 4150 cycles per tick
    localparam int unsigned TICK_CYC = TICK_NS / (1000000000 / CLK_HZ);
    localparam logic [15:0] SET_MAX = 16'h2710;
    localparam logic [15:0] LEVEL_MAX = 16'h4e20;
    localparam logic [15:0] DELAY1_RST = 16'h001e;
    localparam logic [15:0] LEVEL1_RST = 16'h0032;
    localparam logic [15:0] HYST1_RST = 16'h0021;
    localparam logic [15:0] RAMP_RST = 16'h0014;
    localparam logic [15:0] DELAY2_RST = 16'h0000;
    localparam logic [15:0] LEVEL2_RST = 16'h0000;
    localparam logic [15:0] HYST2_RST = 16'h0000;
    localparam logic [8:0] JOG_MAX = 9'h1f4;
    localparam logic [8:0] JOG_RST = 9'h12c;
    localparam logic [3:0] MODE_VARIATION = 4'h3;
    localparam logic [3:0] MODE2_LO = 4'h3;
    localparam logic [3:0] MODE2_HI = 4'h5;

    typedef struct packed {
        logic [3:0] mode;
        logic [15:0] delay;
        logic [15:0] level;
        logic [15:0] hyst;
    } sgsc_set_t;

    typedef enum logic [2:0] {
        ST_FIRST = 3'b001,
        ST_SECOND = 3'b010,
        ST_RETURN = 3'b100
    } sgsc_state_t;

    typedef struct packed {
        sgsc_state_t st;
        logic [15:0] dly_cnt;
        logic [12:0] tick_cnt;
        logic tick;
        logic [15:0] ramp_cnt;
        logic [15:0] ramp_len;
        logic [15:0] kp;
        logic second;
        logic [8:0] jog;
    } sgsc_state_rec_t;
endpackage

// ==== verilog/sgsc_gain_switch.sv ====
// gain switching decision, return delay, position gain ramp and jog speed
// What this block does
// [R1] with first mode 3 the return to first gain waits first delay ticks.
// [R2] the first judging level, 0..20000, default 50, is the threshold.
// [R3] the first hysteresis, 0..20000, default 33, widens it both ways.
// [R4] first level and hysteresis apply to the magnitude of the quantity.
// [R5] a rising position gain ramps step by step over setting+1 ticks; with gain_switch_enable low it is applied at once.
// [R6] with second mode 3 to 5 the return waits second delay ticks.
// [R7] the second judging level, 0..20000, default 0, serves second mode.
// [R8] the second hysteresis, 0..20000, default 0, widens it both ways.
// [R9] second level and hysteresis apply to the magnitude of the quantity.
// [R10] jog runs at the jog speed setting, 0..500 r/min, default 300.
// [R11] first mode 3 selects second gain on large torque variation.
// [R12] above level+hyst go second; below level-hyst start delay, rearm.
`timescale 1ns/100ps
`default_nettype none
module sgsc_gain_switch
    import sgsc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic gain_switch_enable,
    input wire logic use_second_set,
    input wire sgsc_pkg::sgsc_set_t first_set,
    input wire sgsc_pkg::sgsc_set_t second_set,
    input wire logic [15:0] position_gain_ramp_time,
    input wire logic [15:0] first_position_gain_setting,
    input wire logic [15:0] second_position_gain_setting,
    input wire logic signed [16:0] monitored_value,
    input wire logic [8:0] jog_speed_setting,
    output logic second_gain_active,
    output logic [15:0] position_loop_gain,
    output logic [8:0] jog_speed
);
    import sgsc_pkg::*;

    sgsc_state_rec_t s_q;
    sgsc_state_rec_t s_d;
    sgsc_set_t act;
    logic [16:0] mag;
    logic [16:0] upper;
    logic [16:0] lower;
    logic [15:0] dly_set;
    logic [15:0] lvl;
    logic [15:0] hys;
    logic mode_ok;
    logic above;
    logic below;
    logic [15:0] target;
    logic [31:0] step;

    always_comb
    begin
        act = use_second_set ? second_set : first_set;
        if (use_second_set)
        begin
            mode_ok = (act.mode >= MODE2_LO) && (act.mode <= MODE2_HI); // [R6]
        end
        else
        begin
            mode_ok = (act.mode == MODE_VARIATION); // [R1] [R11]
        end
        mode_ok = mode_ok && gain_switch_enable;
        dly_set = (act.delay > SET_MAX) ? SET_MAX : act.delay; // [R1] [R6]
        lvl = (act.level > LEVEL_MAX) ? LEVEL_MAX : act.level; // [R2] [R7]
        hys = (act.hyst > LEVEL_MAX) ? LEVEL_MAX : act.hyst; // [R3] [R8]
        // magnitude so both signs behave alike
        mag = monitored_value[16] ? 17'(-monitored_value)
                                  : 17'(monitored_value); // [R4] [R9]
        upper = 17'(lvl) + 17'(hys); // [R3] [R8]
        lower = (hys > lvl) ? 17'h00000 : 17'(lvl - hys);
        above = mag > upper; // [R12]
        below = mag < lower; // [R12]
    end

    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        step = 32'h0;
        if (s_q.tick_cnt == 13'(TICK_CYC - 1))
        begin
            s_d.tick_cnt = 13'h0000;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.tick_cnt = s_q.tick_cnt + 13'h0001;
        end
        s_d.jog = (jog_speed_setting > JOG_MAX) ? JOG_MAX
                                                : jog_speed_setting; // [R10]
        case (s_q.st)
            ST_FIRST:
            begin
                if (mode_ok && above)
                begin
                    s_d.st = ST_SECOND; // [R11] [R12]
                end
            end
            ST_SECOND:
            begin
                if (!mode_ok)
                begin
                    s_d.st = ST_FIRST;
                end
                else if (below)
                begin
                    s_d.st = ST_RETURN; // [R12]
                    s_d.dly_cnt = dly_set;
                end
            end
            ST_RETURN:
            begin
                if (!mode_ok)
                begin
                    s_d.st = ST_FIRST;
                end
                else if (above)
                begin
                    s_d.st = ST_SECOND; // [R12]
                end
                else if (s_q.dly_cnt == 16'h0000)
                begin
                    s_d.st = ST_FIRST; // [R1] [R6]
                end
                else if (s_q.tick)
                begin
                    s_d.dly_cnt = s_q.dly_cnt - 16'h0001;
                end
            end
            default:
            begin
                s_d.st = ST_FIRST;
            end
        endcase
        s_d.second = (s_d.st != ST_FIRST);
        // position gain: immediate when falling or with switching off, ramped when rising
        target = s_d.second ? second_position_gain_setting
                            : first_position_gain_setting;
        if (target <= s_q.kp)
        begin
            s_d.kp = target;
            s_d.ramp_cnt = 16'h0000;
        end
        else if (!gain_switch_enable)
        begin
            s_d.kp = target;
        end
        else
        begin
            if (s_q.ramp_cnt == 16'h0000)
            begin
                s_d.ramp_len = ((position_gain_ramp_time > SET_MAX)
                    ? SET_MAX : position_gain_ramp_time) + 16'h0001; // [R5]
                s_d.ramp_cnt = s_d.ramp_len;
            end
            if (s_q.tick && s_q.ramp_cnt != 16'h0000)
            begin
                // one even step per tick over the remaining ticks
                step = 32'(target - s_q.kp) / 32'(s_q.ramp_cnt); // [R5]
                if (step == 32'h0)
                begin
                    step = 32'h1;
                end
                s_d.kp = s_q.kp + step[15:0];
                s_d.ramp_cnt = s_q.ramp_cnt - 16'h0001;
                if (s_q.ramp_cnt == 16'h0001)
                begin
                    s_d.kp = target;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            s_q <= '{st: ST_FIRST, jog: JOG_RST, default: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign second_gain_active = s_q.second;
    assign position_loop_gain = s_q.kp;
    assign jog_speed = s_q.jog;

    go_second_a: assert property (@(posedge clk) disable iff (!reset_n) // [R12]
        (s_q.st == ST_FIRST && mode_ok && above) |=> second_gain_active)
        else $error("second gain not taken above level plus hysteresis");
    mode_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
        (!gain_switch_enable) |=> !second_gain_active)
        else $error("second gain active while switching disabled");
    delay_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
        (s_q.st == ST_RETURN && s_q.dly_cnt != 16'h0000 && mode_ok)
        |=> second_gain_active)
        else $error("returned to first gain before delay elapsed");
    delay_end_a: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
        (s_q.st == ST_RETURN && s_q.dly_cnt == 16'h0000 && !above)
        |=> !second_gain_active)
        else $error("return not taken when delay elapsed");
    rearm_delay_a: assert property (@(posedge clk) disable iff (!reset_n) // [R12]
        (s_q.st == ST_RETURN && mode_ok && above) |=> s_q.st == ST_SECOND)
        else $error("return delay not cancelled on rise");
    sign_sym_a: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
        (monitored_value[16] ? (mag + 17'(monitored_value)) == 17'h00000
                             : mag == 17'(monitored_value)))
        else $error("magnitude not symmetric");
    fall_fast_a: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
        (s_q.kp > first_position_gain_setting && !s_d.second)
        |=> position_loop_gain == $past(first_position_gain_setting))
        else $error("falling position gain was ramped");
    ramp_step_a: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
        (gain_switch_enable && target > s_q.kp && !s_q.tick)
        |=> position_loop_gain == $past(s_q.kp))
        else $error("position gain moved between ticks");
    ramp_tick_a: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
        (gain_switch_enable && target > s_q.kp && s_q.tick
         && s_q.ramp_cnt != 16'h0000)
        |=> position_loop_gain > $past(s_q.kp)
            && position_loop_gain <= $past(target))
        else $error("position gain ramp step out of range");
    jog_limit_a: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
        jog_speed <= JOG_MAX)
        else $error("jog speed above limit");
    level_cap_a: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
        lvl <= LEVEL_MAX && hys <= LEVEL_MAX) // [R8] [R3] [R2]
        else $error("judging level or hysteresis above limit");
endmodule // sgsc_gain_switch
`default_nettype wire

// ==== bench/sgsc_loop_model.sv ====
// behavioural control loop that produces the monitored quantity
`timescale 1ns/100ps
`default_nettype none
module sgsc_loop_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] magnitude,
    input wire logic negative,
    output logic signed [16:0] monitored_value
);
    // quantity settles one cycle after the loop command changes
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            monitored_value <= '0;
        else if (negative)
            monitored_value <= -$signed({1'b0, magnitude});
        else
            monitored_value <= $signed({1'b0, magnitude});
    end
endmodule // sgsc_loop_model
`default_nettype wire

// ==== bench/servo_gain_switch_control_test.sv ====
// self-checking bench for the servo gain switch control block
`timescale 1ns/100ps
`default_nettype none
module servo_gain_switch_control_test;
    import sgsc_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, en = 1'b0, use2 = 1'b0, neg = 1'b0;
    sgsc_set_t set1 = '{4'h3, 16'h0002, 16'h0032, 16'h0021};
    sgsc_set_t set2 = '{4'h3, 16'h0000, 16'h0064, 16'h0000};
    logic [15:0] ramp = 16'h0001, kp1 = '0, kp2 = '0, mag = '0, kp;
    logic [8:0] jog_in = 9'h000, jog;
    logic sec;
    logic signed [16:0] mon;
    int failures = 0, num_checks = 0, seed = 93232, n;
    logic [15:0] exp_q[$];
    int sel_q[$];
    event got;
    always #20 clk = ~clk;
    sgsc_loop_model loop (.clk(clk), .reset_n(reset_n), .magnitude(mag),
        .negative(neg), .monitored_value(mon));
    sgsc_gain_switch DUT (.clk(clk), .reset_n(reset_n),
        .gain_switch_enable(en), .use_second_set(use2), .first_set(set1),
        .second_set(set2), .position_gain_ramp_time(ramp),
        .first_position_gain_setting(kp1),
        .second_position_gain_setting(kp2), .monitored_value(mon),
        .jog_speed_setting(jog_in), .second_gain_active(sec),
        .position_loop_gain(kp), .jog_speed(jog));
    function automatic logic [15:0] cur(input int s);
        return s == 0 ? {15'h0000, sec} : s == 1 ? kp :
            s == 2 ? {7'h00, jog} : s == 3 ? {15'h0000, kp != kp1} :
            {15'h0000, kp != kp2};
    endfunction
    // watcher checks every pending note, oldest first, whenever a result is announced
    always @(got)
    begin
        while (exp_q.size() > 0)
        begin
            num_checks++;
            if (cur(sel_q[0]) !== exp_q[0])
            begin
                failures++;
                $display("mismatch at %0t: output %0d got %h expected %h",
                    $time, sel_q[0], cur(sel_q[0]), exp_q[0]);
            end
            void'(exp_q.pop_front());
            void'(sel_q.pop_front());
        end
    end
    task automatic check(input int s, input logic [15:0] e);
        sel_q.push_back(s);
        exp_q.push_back(e);
        -> got;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic put(input logic [15:0] m, input logic ng);
        @(posedge clk);
        mag <= m;
        neg <= ng;
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_for(input int s, input logic [15:0] e, input int lim);
        n = 0;
        while (n < lim && cur(s) !== e)
        begin
            cyc(1);
            n++;
        end
        if (n >= lim)
        begin
            failures++;
            $display("mismatch at %0t: wait ran out", $time);
            complete_run;
        end
    endtask
    initial
    begin
        logic [8:0] v;
        cyc(9);
        check(0, 16'h0000);
        check(2, {7'h00, JOG_RST});
        @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            v = i == 0 ? 9'h1ff : i == 1 ? JOG_MAX :
                9'($unsigned($random(seed)) % 512);
            @(posedge clk);
            jog_in <= v;
            cyc(3);
            check(2, {7'h00, v > JOG_MAX ? JOG_MAX : v});
        end
        $display("jog test done");
        @(posedge clk);
        en <= 1'b1;
        put(16'h0053, 1'b1);
        cyc(3);
        check(0, 16'h0000);
        put(16'h0054, 1'b1);
        cyc(2);
        check(0, 16'h0001);
        put(16'h0011, 1'b0);
        cyc(8400);
        check(0, 16'h0001);
        put(16'h0010, 1'b0);
        cyc(3000);
        check(0, 16'h0001);
        put(16'h0054, 1'b0);
        cyc(3);
        put(16'h0010, 1'b1);
        cyc(4100);
        check(0, 16'h0001);
        wait_for(0, 16'h0000, 4300);
        check(0, 16'h0000);
        $display("first set test done");
        @(posedge clk);
        use2 <= 1'b1;
        for (int m = 3; m <= 5; m++)
        begin
            @(posedge clk);
            set2.mode <= 4'(m);
            put(16'h0064, 1'b0);
            cyc(3);
            check(0, 16'h0000);
            put(16'h0065, 1'b1);
            cyc(3);
            check(0, 16'h0001);
            put(16'h0063, 1'b0);
            cyc(4);
            check(0, 16'h0000);
        end
        @(posedge clk);
        set2.mode <= 4'h2;
        put(16'h01f4, 1'b0);
        cyc(3);
        check(0, 16'h0000);
        $display("second set test done");
        put(16'h0000, 1'b0);
        kp1 <= 16'h0400;
        cyc(4000);
        check(3, 16'h0001);
        wait_for(1, 16'h0400, 8400);
        check(1, 16'h0400);
        @(posedge clk);
        kp1 <= 16'h0100;
        cyc(2);
        check(1, 16'h0100);
        // with switching off a rising gain is applied at once
        @(posedge clk);
        en <= 1'b0;
        kp1 <= 16'h0800;
        cyc(2);
        check(1, 16'h0800);
        // switching to a larger second gain must ramp, not jump
        @(posedge clk);
        en <= 1'b1;
        kp2 <= 16'h0900;
        set2.mode <= 4'h3;
        put(16'h0065, 1'b0);
        cyc(3);
        check(0, 16'h0001);
        check(4, 16'h0001);
        wait_for(1, 16'h0900, 8400);
        check(1, 16'h0900);
        $display("ramp test done");
        cyc(2);
        complete_run;
    end
endmodule // servo_gain_switch_control_test
`default_nettype wire
